/* logic/readout_pkg.sv */
// Constants and types shared by the pixel array readout sequencer
// Notes on behaviour
// - Full array 728x548 read when config 00
// - Colour fixed by row and column parity
// - EvenEven blue, EvenOdd G1, OddEven G2, OddOdd red
// - Eight shielded rows feed black calibration only
// - Programmable horizontal and vertical blanking
// - Config 01 reads only the programmed window
// - Line and frame length follow window size
// - Window pans over 640x480 plus 88x68 border
// - Flip reads rows in reverse order
// - Mirror reads columns in reverse order
// - Flip and mirror work in every mode
// - Config field sits at 0x0006 bits 3:2
package readout_pkg;

  // ----------------------------------------------------------------
  // Array geometry
  // ----------------------------------------------------------------
  localparam int unsigned ARRAY_COLS = 728;
  localparam int unsigned ARRAY_ROWS = 548;
  localparam int unsigned BLACK_ROWS = 8;
  localparam logic [9:0]  FULL_COL_LAST = 10'(ARRAY_COLS - 1);
  localparam logic [9:0]  FULL_ROW_LAST = 10'(ARRAY_ROWS - 1);
  localparam logic [15:0] BLACK_LINE_LAST = 16'(BLACK_ROWS - 1);

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [15:0] OFF_READOUT_CFG   = 16'h0006;
  localparam logic [15:0] OFF_ROW_START_HI  = 16'h0050;
  localparam logic [15:0] OFF_ROW_START_LO  = 16'h0051;
  localparam logic [15:0] OFF_ROW_END_HI    = 16'h0052;
  localparam logic [15:0] OFF_ROW_END_LO    = 16'h0053;
  localparam logic [15:0] OFF_COL_START_HI  = 16'h0054;
  localparam logic [15:0] OFF_COL_START_LO  = 16'h0055;
  localparam logic [15:0] OFF_COL_END_HI    = 16'h0056;
  localparam logic [15:0] OFF_COL_END_LO    = 16'h0057;
  localparam logic [15:0] OFF_READOUT_CTRL  = 16'h0058;
  localparam logic [15:0] OFF_HBLANK_HI     = 16'h0059;
  localparam logic [15:0] OFF_HBLANK_LO     = 16'h005A;
  localparam logic [15:0] OFF_VBLANK_HI     = 16'h005B;
  localparam logic [15:0] OFF_VBLANK_LO     = 16'h005C;
  localparam logic [15:0] OFF_STATUS        = 16'h005D;
  localparam logic [15:0] OFF_BLACK_HI      = 16'h005E;
  localparam logic [15:0] OFF_BLACK_LO      = 16'h005F;
  localparam logic [15:0] OFF_FRAME_COUNT   = 16'h0060;

  // ----------------------------------------------------------------
  // Field positions and codes
  // ----------------------------------------------------------------
  localparam int unsigned CFG_LSB        = 2;
  localparam int unsigned CFG_MSB        = 3;
  localparam logic [1:0]  CFG_FULL       = 2'h0;
  localparam logic [1:0]  CFG_WINDOW     = 2'h1;
  localparam int unsigned CTRL_MIRROR    = 0;
  localparam int unsigned CTRL_FLIP      = 1;
  localparam int unsigned CTRL_RUN       = 2;
  localparam int unsigned STAT_ACTIVE    = 0;
  localparam int unsigned STAT_BLACK     = 1;
  localparam int unsigned STAT_VBLANK    = 2;
  localparam int unsigned BLACK_AVG_SHIFT = 6;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [1:0]  CFG_RST        = 2'h0;
  localparam logic [9:0]  ROW_START_RST  = 10'h000;
  localparam logic [9:0]  COL_START_RST  = 10'h000;
  localparam logic [9:0]  ROW_END_RST    = FULL_ROW_LAST;
  localparam logic [9:0]  COL_END_RST    = FULL_COL_LAST;
  localparam logic        MIRROR_RST     = 1'b0;
  localparam logic        FLIP_RST       = 1'b0;
  localparam logic        RUN_RST        = 1'b0;
  localparam logic [15:0] HBLANK_RST     = 16'h0010;
  localparam logic [15:0] VBLANK_RST     = 16'h0004;

  // Colour of a site, indexed by {row parity, column parity}
  typedef enum logic [1:0] {
    COLOUR_BLUE,
    COLOUR_GREEN_ONE,
    COLOUR_GREEN_TWO,
    COLOUR_RED
  } colour_t;

endpackage

/* logic/readout_axis_map.sv */
// Maps a readout offset to an array coordinate, forward or reversed
`timescale 1ns/1ns
module readout_axis_map #(
  parameter int unsigned COORD_W = 10
) (
  input  wire logic [COORD_W-1:0] offset_i,
  input  wire logic [COORD_W-1:0] start_i,
  input  wire logic [COORD_W-1:0] end_i,
  input  wire logic               reverse_i,
  output logic      [COORD_W-1:0] coord_o
);

  // ----------------------------------------------------------------
  // Forward counts up from start, reverse counts down from end
  // ----------------------------------------------------------------
  always_comb begin
    if (reverse_i) begin
      coord_o = end_i - offset_i;
    end else begin
      coord_o = start_i + offset_i;
    end
  end

endmodule

/* logic/readout_fifo.sv */
// Small valid/ready buffer between the sequencer and the pipeline
`timescale 1ns/1ns
module readout_fifo #(
  parameter int unsigned WIDTH = 14,
  parameter int unsigned DEPTH = 2
) (
  input  wire logic             core_clk_i,
  input  wire logic             resetn_i,
  input  wire logic             ce_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);

  localparam int unsigned PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CNT_W = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0]            wr_ptr;
    logic [PTR_W-1:0]            rd_ptr;
    logic [CNT_W-1:0]            count;
  } fifo_state_t;

  fifo_state_t s;
  fifo_state_t next_s;
  logic        push;
  logic        pop;

  // ----------------------------------------------------------------
  // Handshakes, frozen while the clock enable is low
  // ----------------------------------------------------------------
  assign in_ready_o  = ce_i && (s.count != CNT_W'(DEPTH));
  assign out_valid_o = ce_i && (s.count != '0);
  assign out_data_o  = s.mem[s.rd_ptr];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_comb begin
    next_s = s;
    if (push) begin
      next_s.mem[s.wr_ptr] = in_data_i;
      next_s.wr_ptr = (s.wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : s.wr_ptr + 1'b1;
    end
    if (pop) begin
      next_s.rd_ptr = (s.rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : s.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_s.count = s.count + 1'b1;
    end else if (pop && !push) begin
      next_s.count = s.count - 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s <= '0;
    end else if (ce_i) begin
      s <= next_s;
    end
  end

endmodule

/* logic/pixel_array_window_readout.sv */
// Readout sequencer for the pixel array: window, flip, mirror, blanking
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ns
module pixel_array_window_readout #(
  parameter int unsigned PIX_W     = 10,
  parameter int unsigned BUF_DEPTH = 2
) (
  input  wire logic              core_clk_i,
  input  wire logic              resetn_i,
  input  wire logic              ce_i,
  input  wire logic [15:0]       reg_addr_i,
  input  wire logic [7:0]        reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic      [7:0]        reg_rdata_o,
  output logic      [9:0]        array_row_o,
  output logic      [9:0]        array_col_o,
  output logic                   array_black_o,
  output logic                   array_rd_o,
  input  wire logic [PIX_W-1:0]  array_pix_i,
  output logic                   out_valid_o,
  input  wire logic              out_ready_i,
  output logic      [PIX_W-1:0]  out_pix_o,
  output logic      [1:0]        out_colour_o,
  output logic                   out_sof_o,
  output logic                   out_eol_o
);

  localparam int unsigned WORD_W = PIX_W + 4;

  typedef enum logic [1:0] {
    PH_IDLE,
    PH_BLACK,
    PH_ACTIVE,
    PH_VBLANK
  } phase_t;

  typedef struct packed {
    logic [1:0]  cfg;
    logic [9:0]  row_start;
    logic [9:0]  row_end;
    logic [9:0]  col_start;
    logic [9:0]  col_end;
    logic        mirror;
    logic        flip;
    logic        run;
    logic [15:0] hblank;
    logic [15:0] vblank;
    logic [9:0]  act_row_start;
    logic [9:0]  act_row_end;
    logic [9:0]  act_col_start;
    logic [9:0]  act_col_end;
    logic        act_mirror;
    logic        act_flip;
    logic [15:0] act_hblank;
    logic [15:0] act_vblank;
    phase_t      phase;
    logic [16:0] col;
    logic [15:0] line;
    logic [15:0] black_acc;
    logic [7:0]  frames;
    logic [7:0]  rd_data;
  } state_t;

  state_t           s;
  state_t           next_s;
  logic [10:0]      width;
  logic [10:0]      height;
  logic [16:0]      line_last;
  logic [15:0]      active_last;
  logic             in_pixel;
  logic             emit;
  logic             advance;
  logic [9:0]       map_row;
  logic [9:0]       map_col;
  logic [7:0]       rd_word;
  logic             buf_ready;
  logic             word_sof;
  logic             word_eol;
  logic [1:0]       word_colour;
  logic [WORD_W-1:0] buf_out;
  logic [9:0]       black_level;

  // ----------------------------------------------------------------
  // Geometry of the frame in progress
  // ----------------------------------------------------------------
  assign width       = 11'(s.act_col_end) - 11'(s.act_col_start) + 11'h001;
  assign height      = 11'(s.act_row_end) - 11'(s.act_row_start) + 11'h001;
  assign line_last   = 17'(width) + 17'(s.act_hblank) - 17'h0_0001;
  assign active_last = 16'(height) - 16'h0001;
  assign in_pixel    = (s.col < 17'(width));
  assign emit        = (s.phase == PH_ACTIVE) && in_pixel;
  assign advance     = !emit || buf_ready;
  assign black_level = 10'(s.black_acc >> readout_pkg::BLACK_AVG_SHIFT);

  readout_axis_map #(
    .COORD_W (10)
  ) u_row_map (
    .offset_i  (s.line[9:0]),
    .start_i   (s.act_row_start),
    .end_i     (s.act_row_end),
    .reverse_i (s.act_flip),
    .coord_o   (map_row)
  );

  readout_axis_map #(
    .COORD_W (10)
  ) u_col_map (
    .offset_i  (s.col[9:0]),
    .start_i   (s.act_col_start),
    .end_i     (s.act_col_end),
    .reverse_i (s.act_mirror),
    .coord_o   (map_col)
  );

  // ----------------------------------------------------------------
  // Array addressing and outgoing word
  // ----------------------------------------------------------------
  assign array_black_o = (s.phase == PH_BLACK);
  assign array_row_o   = array_black_o ? 10'(s.line[2:0]) : map_row;
  assign array_col_o   = map_col;
  assign array_rd_o    = ce_i && ((s.phase == PH_ACTIVE) || array_black_o) && in_pixel;
  assign word_colour   = {map_row[0], map_col[0]};
  assign word_sof      = (s.line == 16'h0000) && (s.col == 17'h0_0000);
  assign word_eol      = (s.col == 17'(width) - 17'h0_0001);

  readout_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (BUF_DEPTH)
  ) u_out_buf (
    .core_clk_i  (core_clk_i),
    .resetn_i    (resetn_i),
    .ce_i        (ce_i),
    .in_valid_i  (emit),
    .in_ready_o  (buf_ready),
    .in_data_i   ({word_sof, word_eol, word_colour, array_pix_i}),
    .out_valid_o (out_valid_o),
    .out_ready_i (out_ready_i),
    .out_data_o  (buf_out)
  );

  assign out_sof_o    = buf_out[WORD_W-1];
  assign out_eol_o    = buf_out[WORD_W-2];
  assign out_colour_o = buf_out[WORD_W-3:WORD_W-4];
  assign out_pix_o    = buf_out[PIX_W-1:0];
  assign reg_rdata_o  = s.rd_data;

  // ----------------------------------------------------------------
  // Register read mux
  // ----------------------------------------------------------------
  always_comb begin
    rd_word = 8'h00;
    case (reg_addr_i)
      readout_pkg::OFF_READOUT_CFG:  rd_word = 8'(s.cfg) << readout_pkg::CFG_LSB;
      readout_pkg::OFF_ROW_START_HI: rd_word = 8'(s.row_start[9:8]);
      readout_pkg::OFF_ROW_START_LO: rd_word = s.row_start[7:0];
      readout_pkg::OFF_ROW_END_HI:   rd_word = 8'(s.row_end[9:8]);
      readout_pkg::OFF_ROW_END_LO:   rd_word = s.row_end[7:0];
      readout_pkg::OFF_COL_START_HI: rd_word = 8'(s.col_start[9:8]);
      readout_pkg::OFF_COL_START_LO: rd_word = s.col_start[7:0];
      readout_pkg::OFF_COL_END_HI:   rd_word = 8'(s.col_end[9:8]);
      readout_pkg::OFF_COL_END_LO:   rd_word = s.col_end[7:0];
      readout_pkg::OFF_READOUT_CTRL: begin
        rd_word[readout_pkg::CTRL_MIRROR] = s.mirror;
        rd_word[readout_pkg::CTRL_FLIP]   = s.flip;
        rd_word[readout_pkg::CTRL_RUN]    = s.run;
      end
      readout_pkg::OFF_HBLANK_HI:    rd_word = s.hblank[15:8];
      readout_pkg::OFF_HBLANK_LO:    rd_word = s.hblank[7:0];
      readout_pkg::OFF_VBLANK_HI:    rd_word = s.vblank[15:8];
      readout_pkg::OFF_VBLANK_LO:    rd_word = s.vblank[7:0];
      readout_pkg::OFF_STATUS: begin
        rd_word[readout_pkg::STAT_ACTIVE] = (s.phase != PH_IDLE);
        rd_word[readout_pkg::STAT_BLACK]  = (s.phase == PH_BLACK);
        rd_word[readout_pkg::STAT_VBLANK] = (s.phase == PH_VBLANK);
      end
      readout_pkg::OFF_BLACK_HI:     rd_word = 8'(black_level[9:8]);
      readout_pkg::OFF_BLACK_LO:     rd_word = black_level[7:0];
      readout_pkg::OFF_FRAME_COUNT:  rd_word = s.frames;
      default:                       rd_word = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state: registers and sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.rd_data = reg_rd_i ? rd_word : 8'h00;
    if (reg_wr_i) begin
      case (reg_addr_i)
        readout_pkg::OFF_READOUT_CFG: begin
          next_s.cfg = reg_wdata_i[readout_pkg::CFG_MSB:readout_pkg::CFG_LSB];
        end
        readout_pkg::OFF_ROW_START_HI: next_s.row_start[9:8] = reg_wdata_i[1:0];
        readout_pkg::OFF_ROW_START_LO: next_s.row_start[7:0] = reg_wdata_i;
        readout_pkg::OFF_ROW_END_HI:   next_s.row_end[9:8]   = reg_wdata_i[1:0];
        readout_pkg::OFF_ROW_END_LO:   next_s.row_end[7:0]   = reg_wdata_i;
        readout_pkg::OFF_COL_START_HI: next_s.col_start[9:8] = reg_wdata_i[1:0];
        readout_pkg::OFF_COL_START_LO: next_s.col_start[7:0] = reg_wdata_i;
        readout_pkg::OFF_COL_END_HI:   next_s.col_end[9:8]   = reg_wdata_i[1:0];
        readout_pkg::OFF_COL_END_LO:   next_s.col_end[7:0]   = reg_wdata_i;
        readout_pkg::OFF_READOUT_CTRL: begin
          next_s.mirror = reg_wdata_i[readout_pkg::CTRL_MIRROR];
          next_s.flip   = reg_wdata_i[readout_pkg::CTRL_FLIP];
          next_s.run    = reg_wdata_i[readout_pkg::CTRL_RUN];
        end
        readout_pkg::OFF_HBLANK_HI:    next_s.hblank[15:8] = reg_wdata_i;
        readout_pkg::OFF_HBLANK_LO:    next_s.hblank[7:0]  = reg_wdata_i;
        readout_pkg::OFF_VBLANK_HI:    next_s.vblank[15:8] = reg_wdata_i;
        readout_pkg::OFF_VBLANK_LO:    next_s.vblank[7:0]  = reg_wdata_i;
        default: ;
      endcase
    end
    if (array_black_o && in_pixel) begin
      next_s.black_acc = s.black_acc + 16'(array_pix_i)
                         - (s.black_acc >> readout_pkg::BLACK_AVG_SHIFT);
    end
    case (s.phase)
      PH_IDLE: begin
        if (s.run) begin
          next_s.act_mirror = s.mirror;
          next_s.act_flip   = s.flip;
          next_s.act_hblank = s.hblank;
          next_s.act_vblank = s.vblank;
          if (s.cfg == readout_pkg::CFG_WINDOW) begin
            next_s.act_row_start = s.row_start;
            next_s.act_row_end   = s.row_end;
            next_s.act_col_start = s.col_start;
            next_s.act_col_end   = s.col_end;
          end else begin
            next_s.act_row_start = 10'h000;
            next_s.act_row_end   = readout_pkg::FULL_ROW_LAST;
            next_s.act_col_start = 10'h000;
            next_s.act_col_end   = readout_pkg::FULL_COL_LAST;
          end
          next_s.col   = 17'h0_0000;
          next_s.line  = 16'h0000;
          next_s.phase = PH_BLACK;
        end
      end
      PH_BLACK, PH_ACTIVE, PH_VBLANK: begin
        if (advance) begin
          if (s.col == line_last) begin
            next_s.col  = 17'h0_0000;
            next_s.line = s.line + 16'h0001;
            if (s.phase == PH_BLACK && s.line == readout_pkg::BLACK_LINE_LAST) begin
              next_s.line  = 16'h0000;
              next_s.phase = PH_ACTIVE;
            end else if (s.phase == PH_ACTIVE && s.line == active_last) begin
              next_s.line  = 16'h0000;
              next_s.phase = (s.act_vblank == 16'h0000) ? PH_IDLE : PH_VBLANK;
              next_s.frames = (s.act_vblank == 16'h0000) ? s.frames + 8'h01 : s.frames;
            end else if (s.phase == PH_VBLANK && s.line == s.act_vblank - 16'h0001) begin
              next_s.line   = 16'h0000;
              next_s.phase  = PH_IDLE;
              next_s.frames = s.frames + 8'h01;
            end
          end else begin
            next_s.col = s.col + 17'h0_0001;
          end
        end
      end
      default: begin
        next_s.phase = PH_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s               <= '0;
      s.cfg           <= readout_pkg::CFG_RST;
      s.row_start     <= readout_pkg::ROW_START_RST;
      s.row_end       <= readout_pkg::ROW_END_RST;
      s.col_start     <= readout_pkg::COL_START_RST;
      s.col_end       <= readout_pkg::COL_END_RST;
      s.mirror        <= readout_pkg::MIRROR_RST;
      s.flip          <= readout_pkg::FLIP_RST;
      s.run           <= readout_pkg::RUN_RST;
      s.hblank        <= readout_pkg::HBLANK_RST;
      s.vblank        <= readout_pkg::VBLANK_RST;
      s.act_row_end   <= readout_pkg::ROW_END_RST;
      s.act_col_end   <= readout_pkg::COL_END_RST;
      s.act_hblank    <= readout_pkg::HBLANK_RST;
      s.act_vblank    <= readout_pkg::VBLANK_RST;
      s.phase         <= PH_IDLE;
    end else if (ce_i) begin
      s <= next_s;
    end
  end

endmodule

/* tb/readout_chk.sv */
// Port checker for the readout sequencer
`timescale 1ns/1ns
module readout_chk #(
  parameter int unsigned PIX_W     = 10,
  parameter int unsigned BUF_DEPTH = 2
) (
  input wire logic             core_clk_i,
  input wire logic             resetn_i,
  input wire logic             ce_i,
  input wire logic             reg_rd_i,
  input wire logic [7:0]       reg_rdata_o,
  input wire logic [9:0]       array_row_o,
  input wire logic [9:0]       array_col_o,
  input wire logic             array_black_o,
  input wire logic             array_rd_o,
  input wire logic             out_valid_o,
  input wire logic             out_ready_i,
  input wire logic [PIX_W-1:0] out_pix_o,
  input wire logic [1:0]       out_colour_o,
  input wire logic             out_sof_o,
  input wire logic             out_eol_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  chk_rdata_idle: assert property ($past(ce_i) && !$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
    else $error("read data outside read answer");
  chk_word_hold: assert property (out_valid_o && !out_ready_i |=> !ce_i || (out_valid_o && $stable(out_pix_o)
    && $stable(out_colour_o) && $stable(out_sof_o) && $stable(out_eol_o))) else $error("stalled word changed");
  chk_black_row: assert property (array_black_o |-> array_row_o < 10'h008)
    else $error("black row out of range");
  chk_black_len: assert property ($rose(array_black_o) |-> array_black_o [*8])
    else $error("black phase too short");
  chk_row_range: assert property (array_rd_o && !array_black_o |-> array_row_o < 10'h224)
    else $error("row outside array");
  chk_col_range: assert property (array_rd_o |-> array_col_o < 10'h2d8)
    else $error("column outside array");
  chk_ce_gate: assert property (!ce_i |-> !out_valid_o && !array_rd_o)
    else $error("activity with enable low");
  chk_col_step: assert property (array_rd_o && $past(array_rd_o) && array_row_o == $past(array_row_o)
    && array_col_o != $past(array_col_o) |-> array_col_o == $past(array_col_o) + 10'h001
    || array_col_o == $past(array_col_o) - 10'h001) else $error("column skipped");
  cov_sof: cover property (out_valid_o && out_ready_i && out_sof_o);
  cov_eol: cover property (out_valid_o && out_ready_i && out_eol_o);
  cov_stall: cover property (out_valid_o && !out_ready_i);
  cov_black: cover property ($rose(array_black_o));
endmodule

bind pixel_array_window_readout readout_chk #(.PIX_W(PIX_W), .BUF_DEPTH(BUF_DEPTH)) u_chk (
  .core_clk_i(core_clk_i), .resetn_i(resetn_i), .ce_i(ce_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .array_row_o(array_row_o), .array_col_o(array_col_o), .array_black_o(array_black_o), .array_rd_o(array_rd_o),
  .out_valid_o(out_valid_o), .out_ready_i(out_ready_i), .out_pix_o(out_pix_o), .out_colour_o(out_colour_o),
  .out_sof_o(out_sof_o), .out_eol_o(out_eol_o));

/* tb/far_side_model.sv */
// Pixel array contents and image pipeline sink
`timescale 1ns/1ns
module far_side_model #(
  parameter int unsigned PIX_W = 10
) (
  input  wire logic [9:0]       row_i,
  input  wire logic [9:0]       col_i,
  input  wire logic             black_i,
  input  wire logic             stall_i,
  output logic      [PIX_W-1:0] pix_o,
  output logic                  ready_o
);
  // Shielded rows give a flat level, image sites a coded address
  assign pix_o   = black_i ? PIX_W'(10'h040) : PIX_W'(row_i * 10'h01d + col_i);
  assign ready_o = !stall_i;
endmodule

/* tb/testbench.sv */
// Self-checking bench for the readout sequencer
`timescale 1ns/1ns
module testbench;
  typedef struct packed {logic [9:0] rs, re, cs, ce; logic mi, fl;} geom_t;
  localparam logic [15:0] ra [9] = '{16'h0006, 16'h0052, 16'h0053, 16'h0056, 16'h0057, 16'h0058, 16'h005a,
                                     16'h005c, 16'h0100};
  localparam logic [7:0]  rv [9] = '{8'h00, 8'h02, 8'h23, 8'h02, 8'hd7, 8'h00, 8'h10, 8'h04, 8'h00};
  logic        core_clk_i = 0, resetn_i = 0, ce_i = 1, reg_wr_i = 0, reg_rd_i = 0, stall = 0;
  logic [15:0] reg_addr_i = 0;
  logic [7:0]  reg_wdata_i = 0, reg_rdata_o;
  logic [9:0]  array_row_o, array_col_o, array_pix_i, out_pix_o, er, ec;
  logic [1:0]  out_colour_o;
  logic        array_black_o, array_rd_o, out_valid_o, out_ready_i, out_sof_o, out_eol_o;
  logic [31:0] seed = 32'h0000_1087;
  int          error_cnt = 0, n_checks = 0, nsof = 0, ln = 0, ps = 0, cyc = 0, tq[$];
  geom_t       gq[$], g;
  pixel_array_window_readout #(.PIX_W(10), .BUF_DEPTH(2)) dut (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
    .ce_i(ce_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .array_row_o(array_row_o), .array_col_o(array_col_o),
    .array_black_o(array_black_o), .array_rd_o(array_rd_o), .array_pix_i(array_pix_i),
    .out_valid_o(out_valid_o), .out_ready_i(out_ready_i), .out_pix_o(out_pix_o),
    .out_colour_o(out_colour_o), .out_sof_o(out_sof_o), .out_eol_o(out_eol_o));
  far_side_model #(.PIX_W(10)) far (.row_i(array_row_o), .col_i(array_col_o), .black_i(array_black_o),
    .stall_i(stall), .pix_o(array_pix_i), .ready_o(out_ready_i));
  always #4 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) cyc <= cyc + 1;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic [9:0] pix_of(input logic [9:0] r, c);
    return r * 10'h01d + c;
  endfunction
  task automatic cmp(input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_rd_i <= 0;
    reg_wr_i <= 1;
    @(posedge core_clk_i);
  endtask
  task automatic rchk(input logic [15:0] a, input logic [7:0] e);
    reg_addr_i <= a;
    reg_wr_i <= 0;
    reg_rd_i <= 1;
    @(posedge core_clk_i);
    reg_rd_i <= 0;
    @(posedge core_clk_i);
    cmp(32'(reg_rdata_o), 32'(e));
  endtask
  task automatic setw(input geom_t w, input logic [7:0] ctl);
    gq.push_back(w);
    wr(16'h0050, 8'(w.rs[9:8]));
    wr(16'h0051, w.rs[7:0]);
    wr(16'h0052, 8'(w.re[9:8]));
    wr(16'h0053, w.re[7:0]);
    wr(16'h0054, 8'(w.cs[9:8]));
    wr(16'h0055, w.cs[7:0]);
    wr(16'h0056, 8'(w.ce[9:8]));
    wr(16'h0057, w.ce[7:0]);
    wr(16'h0058, ctl);
    rchk(16'h0058, ctl);
  endtask
  task automatic wsof(input int n);
    for (int i = 0; i < 5000 && nsof < n; i++) @(posedge core_clk_i);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Stream monitor
  // ----------------------------------------------------------------
  always @(posedge core_clk_i) begin
    if (!resetn_i) begin
      ln = 0;
      ps = 0;
      nsof = 0;
      tq.delete();
      gq.delete();
    end else if (out_valid_o && out_ready_i) begin
      if (ln == 0 && ps == 0) begin
        g = gq.pop_front();
        nsof++;
        tq.push_back(cyc);
      end
      er = g.fl ? g.re - 10'(ln) : g.rs + 10'(ln);
      ec = g.mi ? g.ce - 10'(ps) : g.cs + 10'(ps);
      cmp({out_pix_o, out_colour_o, out_sof_o, out_eol_o}, {pix_of(er, ec), er[0], ec[0], ln == 0 && ps == 0,
          ps == int'(g.ce - g.cs)});
      if (ps == int'(g.ce - g.cs)) begin
        ps = 0;
        ln = (ln == int'(g.re - g.rs)) ? 0 : ln + 1;
      end else ps++;
    end
  end
  initial begin
    repeat (20000) @(posedge core_clk_i);
    error_cnt++;
    summarize();
  end
  initial begin
    repeat (12) @(posedge core_clk_i);
    resetn_i <= 1;
    @(posedge core_clk_i);
    for (int i = 0; i < 9; i++) rchk(ra[i], rv[i]);
    wr(16'h0006, 8'hff);
    rchk(16'h0006, 8'h0c);
    wr(16'h0100, 8'h5a);
    rchk(16'h0100, 8'h00);
    gq.push_back(geom_t'{10'h000, 10'h223, 10'h000, 10'h2d7, 1'b0, 1'b0});
    wr(16'h0006, 8'h00);
    wr(16'h005a, 8'h01);
    wr(16'h0058, 8'h04);
    rchk(16'h0058, 8'h04);
    for (int i = 0; i < 9000 && ln < 2; i++) @(posedge core_clk_i);
    cmp(32'(ln), 32'h0000_0002);
    rchk(16'h005d, 8'h01);
    rchk(16'h005f, 8'h40);
    rchk(16'h005e, 8'h00);
    resetn_i <= 0;
    repeat (2) @(posedge core_clk_i);
    resetn_i <= 1;
    @(posedge core_clk_i);
    $display("test full array done");
    wr(16'h0006, 8'h04);
    wr(16'h005a, 8'h01);
    wr(16'h005c, 8'h02);
    wr(16'h0050, 8'hfe);
    rchk(16'h0050, 8'h02);
    setw(geom_t'{10'h004, 10'h009, 10'h002, 10'h00d, 1'b1, 1'b0}, 8'h05);
    $display("test registers done");
    gq.push_back(gq[0]);
    while (nsof < 2) begin
      seed = xs(seed);
      ce_i <= seed[4:0] != 0;
      stall <= seed[9:7] == 0;
      @(posedge core_clk_i);
    end
    ce_i <= 1;
    stall <= 0;
    $display("test window and mirror done");
    setw(geom_t'{10'h212, 10'h223, 10'h2ca, 10'h2d7, 1'b1, 1'b1}, 8'h07);
    wsof(3);
    setw(geom_t'{10'h01e, 10'h021, 10'h028, 10'h02f, 1'b0, 1'b1}, 8'h06);
    wsof(4);
    wr(16'h0058, 8'h02);
    rchk(16'h0058, 8'h02);
    repeat (2000) @(posedge core_clk_i);
    cmp(32'(nsof), 32'h0000_0004);
    cmp(32'(ln + ps), 32'h0000_0000);
    rchk(16'h0060, 8'h04);
    rchk(16'h005d, 8'h00);
    cmp(32'(tq[3] - tq[2]), 32'((18 + 2) * (14 + 1) + 1 + readout_pkg::BLACK_ROWS * (8 + 1)));
    $display("test flip and timing done");
    summarize();
  end
endmodule
